// >>> hw/qe_decoder.sv
// Quadrature and clock/direction decoder producing step events
`timescale 1ns/1ns
module qe_decoder (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Configuration and enable
  input  wire qe_pkg::dec_cfg_t cfg_i,
  input  wire logic             run_i,
  // Encoder pins
  input  wire logic             phase_a_input_i,
  input  wire logic             phase_b_input_i,
  input  wire logic             marker_i,
  // Decoded events
  output qe_pkg::step_t         ev_o
);

  // ----------------------------------------------------------------
  // Channel selection and history
  // ----------------------------------------------------------------
  logic a_now;   // Channel A after swap
  logic b_now;   // Channel B after swap
  logic a_old;   // Previous A
  logic b_old;   // Previous B
  logic m_old;   // Previous marker
  qe_pkg::step_t next_ev;  // Event for this cycle

  // Swap before any decoding
  assign a_now = cfg_i.swap ? phase_b_input_i : phase_a_input_i;
  assign b_now = cfg_i.swap ? phase_a_input_i : phase_b_input_i;

  // History follows pins even when idle, so enabling gives no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_old <= 1'b0;
      b_old <= 1'b0;
      m_old <= 1'b0;
    end else if (ce_i) begin
      a_old <= a_now;
      b_old <= b_now;
      m_old <= marker_i;
    end
  end

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  always_comb begin
    next_ev = '0;
    if (cfg_i.clkdir) begin
      // Rising step clock advances in the direction level
      next_ev.step    = a_now & ~a_old;
      next_ev.reverse = b_now;
    end else begin
      // Both channels moving together is illegal
      next_ev.error = (a_now ^ a_old) & (b_now ^ b_old);
      if (!next_ev.error) begin
        if (a_now ^ a_old) begin
          // A edge: forward when A leads B
          next_ev.step    = 1'b1;
          next_ev.reverse = ~(a_now ^ b_now);
        end else if ((b_now ^ b_old) && cfg_i.cap_ab) begin
          // B edge counted only when both channels selected
          next_ev.step    = 1'b1;
          next_ev.reverse = a_now ^ b_now;
        end
      end
    end
    next_ev.marker = marker_i & ~m_old;
  end

  // Registered events; gated by enable so idle pins are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_o <= '0;
    end else if (ce_i) begin
      ev_o <= run_i ? next_ev : '0;
    end
  end

endmodule // qe_decoder

// >>> hw/qe_pkg.sv
// Package: register map, field layout, types and constants of the quadrature encoder
package qe_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;  // Enable, mode, swap, capture, index reset, velocity enable
  localparam logic [7:0] OFS_STATUS   = 8'h04;  // Direction and error
  localparam logic [7:0] OFS_POS      = 8'h08;  // Position counter
  localparam logic [7:0] OFS_MAXPOS   = 8'h0C;  // Maximum position
  localparam logic [7:0] OFS_LOAD     = 8'h10;  // Velocity period in clocks
  localparam logic [7:0] OFS_TIME     = 8'h14;  // Velocity timer
  localparam logic [7:0] OFS_COUNT    = 8'h18;  // Running pulse count
  localparam logic [7:0] OFS_SPEED    = 8'h1C;  // Saved pulse count
  localparam logic [7:0] OFS_INTEN    = 8'h20;  // Interrupt mask
  localparam logic [7:0] OFS_RIS      = 8'h24;  // Raw interrupt status
  localparam logic [7:0] OFS_ISC      = 8'h28;  // Masked status, write one to clear

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN      = 0;  // Unit enable
  localparam int CTRL_SWAP    = 1;  // Swap channels
  localparam int CTRL_CLKDIR  = 2;  // Clock/direction mode
  localparam int CTRL_CAP_AB  = 3;  // Count both channels
  localparam int CTRL_RST_IDX = 4;  // Reset on marker
  localparam int CTRL_VEL_EN  = 5;  // Velocity capture enable
  localparam int CTRL_DIV_LO  = 6;  // Predivider exponent, 3 bits
  localparam int CTRL_W       = 9;  // Control width

  // Interrupt bits
  localparam int IRQ_MARKER = 0;  // Marker pulse
  localparam int IRQ_PERIOD = 1;  // Velocity period end
  localparam int IRQ_DIR    = 2;  // Direction change
  localparam int IRQ_ERROR  = 3;  // Phase error
  localparam int IRQ_W      = 4;  // Number of sources

  // Reset values
  localparam logic [31:0] MAXPOS_RST = 32'hFFFF_FFFF;  // Full range
  localparam logic [31:0] LOAD_RST   = 32'h0000_0001;  // Non-zero period
  localparam logic [2:0]  DIV_MAX    = 3'h7;            // Divide by 128

  // Decoder outputs travelling together
  typedef struct packed {
    logic step;     // One counted edge
    logic reverse;  // Step direction, 1 = reverse
    logic error;    // Both channels changed at once
    logic marker;   // Marker rising edge
  } step_t;

  // Configuration travelling together
  typedef struct packed {
    logic swap;     // Exchange channels
    logic clkdir;   // Clock/direction mode
    logic cap_ab;   // Count both channels
  } dec_cfg_t;

endpackage

// >>> hw/qe_top.sv
// Quadrature encoder position and velocity unit with Wishbone registers
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module qe_top (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Encoder pins
  input  wire logic        phase_a_input_i,
  input  wire logic        phase_b_input_i,
  input  wire logic        marker_i,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [qe_pkg::CTRL_W-1:0] ctrl;     // Control word
  logic [31:0]               position; // Position counter
  logic [31:0]               maxpos;   // Maximum position
  logic [31:0]               period;   // Velocity period
  logic [qe_pkg::IRQ_W-1:0]  mask;     // Interrupt mask
  logic [qe_pkg::IRQ_W-1:0]  raw;      // Sticky flags
  logic                      reverse;  // Direction status, 1 = reverse
  logic                      error;    // Sticky error indicator
  logic [31:0]               timer;    // Velocity timer
  logic [31:0]               count;    // Running count
  logic [31:0]               speed;    // Saved count
  logic                      expire;   // Period end pulse

  // Decoded control
  logic                      run;      // Unit enabled
  logic                      vel_run;  // Velocity enabled and unit enabled
  qe_pkg::dec_cfg_t          dcfg;     // Decoder configuration
  qe_pkg::step_t             ev;       // Decoder events

  // Bus decode
  logic                      acc;      // Bus access this cycle
  logic                      wr;       // Write strobe
  logic [31:0]               wmask;    // Byte-lane mask
  logic [qe_pkg::IRQ_W-1:0]  events;   // Event set vector
  logic [qe_pkg::IRQ_W-1:0]  clr;      // Clear vector
  logic [31:0]               next_dat; // Read mux

  assign run          = ctrl[qe_pkg::CTRL_EN];
  assign vel_run      = run && ctrl[qe_pkg::CTRL_VEL_EN];
  assign dcfg.swap    = ctrl[qe_pkg::CTRL_SWAP];
  assign dcfg.clkdir  = ctrl[qe_pkg::CTRL_CLKDIR];
  assign dcfg.cap_ab  = ctrl[qe_pkg::CTRL_CAP_AB];

  // Merge a write into an old value by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // Address match for a write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  qe_decoder u_dec (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .ce_i            (ce_i),
    .cfg_i           (dcfg),
    .run_i           (run),
    .phase_a_input_i (phase_a_input_i),
    .phase_b_input_i (phase_b_input_i),
    .marker_i        (marker_i),
    .ev_o            (ev)
  );

  qe_velocity #(.W(32)) u_vel (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .run_i    (vel_run),
    .div_i    (ctrl[qe_pkg::CTRL_DIV_LO +: 3]),
    .period_i (period),
    .step_i   (ev.step),
    .timer_o  (timer),
    .count_o  (count),
    .speed_o  (speed),
    .expire_o (expire)
  );

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state: ack one cycle after strobe, dropped the cycle after
  assign acc   = cyc_i && stb_i && !ack_o;
  assign wr    = acc && we_i && ce_i;
  assign wmask = merge(32'h0000_0000, 32'hFFFF_FFFF, sel_i);

  // Acknowledge every address, mapped or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= acc;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software programs these before setting enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= '0;
      maxpos <= qe_pkg::MAXPOS_RST;
      period <= qe_pkg::LOAD_RST;
      mask   <= '0;
    end else if (wr) begin
      if (hit(adr_i, qe_pkg::OFS_CTRL))   ctrl   <= qe_pkg::CTRL_W'(merge(32'(ctrl), dat_i, sel_i));
      if (hit(adr_i, qe_pkg::OFS_MAXPOS)) maxpos <= merge(maxpos, dat_i, sel_i);
      if (hit(adr_i, qe_pkg::OFS_LOAD))   period <= merge(period, dat_i, sel_i);
      if (hit(adr_i, qe_pkg::OFS_INTEN))  mask   <= qe_pkg::IRQ_W'(merge(32'(mask), dat_i, sel_i));
    end
  end

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  // Software write wins; then marker reset; then stepping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position <= '0;
    end else if (ce_i) begin
      if (wr && hit(adr_i, qe_pkg::OFS_POS)) begin
        position <= merge(position, dat_i, sel_i);
      end else if (run && ev.marker && ctrl[qe_pkg::CTRL_RST_IDX]) begin
        position <= reverse ? maxpos : '0;
      end else if (ev.step) begin
        if (ev.reverse) begin
          position <= (position == '0) ? maxpos : position - 32'h0000_0001;
        end else begin
          position <= (position >= maxpos) ? '0 : position + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Direction and error status
  // ----------------------------------------------------------------
  // Direction holds after motion stops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reverse <= 1'b0;
    end else if (ce_i && ev.step) begin
      reverse <= ev.reverse;
    end
  end

  // Error is sticky; cleared with its interrupt flag, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error <= 1'b0;
    end else if (ce_i) begin
      if (ev.error) error <= 1'b1;
      else if (clr[qe_pkg::IRQ_ERROR]) error <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[qe_pkg::IRQ_MARKER] = ev.marker;
    events[qe_pkg::IRQ_PERIOD] = expire;
    events[qe_pkg::IRQ_DIR]    = ev.step && (ev.reverse != reverse);
    events[qe_pkg::IRQ_ERROR]  = ev.error;
  end

  // Write one to clear, per source
  assign clr = (wr && hit(adr_i, qe_pkg::OFS_ISC)) ? qe_pkg::IRQ_W'(dat_i & wmask) : '0;

  // Flags stay until cleared; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw <= '0;
    end else if (ce_i) begin
      raw <= (raw & ~clr) | events;
    end
  end

  assign irq_o = |(raw & mask);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      qe_pkg::OFS_CTRL:   next_dat = 32'(ctrl);
      qe_pkg::OFS_STATUS: next_dat = {30'h0000_0000, error, reverse};
      qe_pkg::OFS_POS:    next_dat = position;
      qe_pkg::OFS_MAXPOS: next_dat = maxpos;
      qe_pkg::OFS_LOAD:   next_dat = period;
      qe_pkg::OFS_TIME:   next_dat = timer;
      qe_pkg::OFS_COUNT:  next_dat = count;
      qe_pkg::OFS_SPEED:  next_dat = speed;
      qe_pkg::OFS_INTEN:  next_dat = 32'(mask);
      qe_pkg::OFS_RIS:    next_dat = 32'(raw);
      qe_pkg::OFS_ISC:    next_dat = 32'(raw & mask);
      default:            next_dat = 32'h0000_0000;
    endcase
  end

  // Read data registered with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (ce_i && acc) begin
      dat_o <= next_dat;
    end
  end

endmodule // qe_top

// >>> hw/qe_velocity.sv
// Velocity unit: predivider, period timer and pulse accumulator
`timescale 1ns/1ns
module qe_velocity #(
  parameter int W = 32  // Counter width
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Control
  input  wire logic         run_i,
  input  wire logic [2:0]   div_i,
  input  wire logic [W-1:0] period_i,
  input  wire logic         step_i,
  // Results
  output logic [W-1:0]      timer_o,
  output logic [W-1:0]      count_o,
  output logic [W-1:0]      speed_o,
  output logic              expire_o
);

  // Narrower counters cannot hold a full prescaled period
  if (W < 8) begin : g_bad_width
    $error("qe_velocity: width too small");
  end

  // ----------------------------------------------------------------
  // Predivider
  // ----------------------------------------------------------------
  logic [6:0] pre;       // Step prescale counter
  logic [6:0] pre_top;   // Last prescale value
  logic       div_step;  // Divided pulse
  logic       last;      // Timer at end of period

  assign pre_top  = 7'((8'h01 << div_i) - 8'h01);
  assign div_step = step_i && (pre == pre_top);
  assign last     = (timer_o == '0);

  // Prescaler counts position steps only; a low enable freezes even the idle clear
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !run_i)) begin
      pre <= '0;
    end else if (ce_i && step_i) begin
      pre <= div_step ? 7'h00 : 7'(pre + 7'h01);
    end
  end

  // ----------------------------------------------------------------
  // Timer and accumulator
  // ----------------------------------------------------------------
  // Timer counts down period_i clocks; a zero period acts as one
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && !run_i)) begin
      timer_o  <= '0;
      count_o  <= '0;
      expire_o <= 1'b0;
    end else if (ce_i) begin
      expire_o <= last;
      if (last) begin
        timer_o <= (period_i == '0) ? '0 : W'(period_i - 1'b1);
        count_o <= W'(div_step);
      end else begin
        timer_o <= W'(timer_o - 1'b1);
        count_o <= W'(count_o + W'(div_step));
      end
    end
  end

  // Saved count for readback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_o <= '0;
    end else if (ce_i && run_i && last) begin
      speed_o <= count_o;
    end
  end

endmodule // qe_velocity

// >>> tb/qe_checker.sv
// Checker: bus, reset and interrupt relations at the unit's ports
`timescale 1ns/1ns
module qe_checker (
  // Clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Interrupt
  input wire logic        irq_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take;     // Request accepted at this edge
  logic       wr;       // Write cycle on the bus
  logic       en_q;     // Shadow of the unit enable
  logic [2:0] dis_cnt;  // Cycles spent disabled, saturating
  assign take = cyc_i && stb_i && !ack_o && ce_i;
  assign wr   = cyc_i && stb_i && we_i;
  // Enable shadow from control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) en_q <= 1'b0;
    else if (take && we_i && adr_i == qe_pkg::OFS_CTRL && sel_i[0]) en_q <= dat_i[qe_pkg::CTRL_EN];
  end
  // Events in flight may land just after disable, so wait a few cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || en_q) dis_cnt <= 3'h0;
    else if (dis_cnt != 3'h7) dis_cnt <= dis_cnt + 3'h1;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_ack_follows: assert property (take |=> ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0)
    else $error("outputs busy after reset");
  chk_unmapped_zero: assert property (take && !we_i && adr_i > qe_pkg::OFS_ISC |=> dat_o == 32'h0)
    else $error("unmapped read gave data");
  chk_dat_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data moved while idle");
  chk_mask_off: assert property (take && wr && adr_i == qe_pkg::OFS_INTEN && sel_i == 4'hF && dat_i == 32'h0 |=> !irq_o [*2])
    else $error("interrupt with all sources masked");
  chk_flag_holds: assert property (irq_o && !wr |=> irq_o)
    else $error("interrupt dropped without clear");
  chk_idle_quiet: assert property (dis_cnt > 3'h3 && !irq_o && !wr |=> !irq_o)
    else $error("interrupt raised while disabled");
  // Main scenarios reached
  cov_irq_rise: cover property ($rose(irq_o));
  cov_unmapped: cover property (take && adr_i > qe_pkg::OFS_ISC);
  cov_idle_access: cover property (dis_cnt == 3'h7 && take);
endmodule // qe_checker

bind qe_top qe_checker u_qe_checker (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o)
);

// >>> tb/qe_enc_model.sv
// Encoder model: quadrature, clock/direction, glitch and marker stimuli
`timescale 1ns/1ns
module qe_enc_model (
  // Clock
  input  wire logic clk_i,
  // Encoder pins
  output logic      a_o,
  output logic      b_o,
  output logic      marker_o
);
  logic [1:0] ph;  // Gray index of the shaft
  // Shaft at rest, all pins low
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
    marker_o = 1'b0;
    ph = 2'h0;
  end
  // Each pin state stands four clocks, well apart from the sampler
  task automatic hold();
    repeat (4) @(posedge clk_i);
  endtask
  // Quadrature edges; forward means A leads B by a quarter cycle
  task automatic move(input int n, input logic rev);
    repeat (n) begin
      ph = rev ? ph - 2'h1 : ph + 2'h1;
      a_o <= ph[1] ^ ph[0];
      b_o <= ph[1];
      hold();
    end
  endtask
  // Step clock on A, direction level on B set up first
  task automatic cd_step(input logic rev);
    b_o <= rev;
    hold();
    a_o <= 1'b1;
    hold();
    a_o <= 1'b0;
    hold();
    ph = {rev, rev};
  endtask
  // Both channels flip at once: an illegal jump
  task automatic glitch();
    ph = ph + 2'h2;
    a_o <= ph[1] ^ ph[0];
    b_o <= ph[1];
    hold();
  endtask
  // Marker pulse
  task automatic mark();
    marker_o <= 1'b1;
    hold();
    marker_o <= 1'b0;
    hold();
  endtask
endmodule // qe_enc_model

// >>> tb/test_quadrature_encoder_position_velocity.sv
// Testbench: register-level tests of the quadrature encoder unit
`timescale 1ns/1ns
module test_quadrature_encoder_position_velocity;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        pa;        // Channel A pin
  logic        pb;        // Channel B pin
  logic        mk;        // Marker pin
  logic        irq_o;
  logic [31:0] rdat;      // Last word read
  int          n_errors;
  int          n_checks;
  qe_top u_qe_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .phase_a_input_i(pa), .phase_b_input_i(pb), .marker_i(mk), .irq_o(irq_o));
  qe_enc_model enc (.clk_i(clk_i), .a_o(pa), .b_o(pb), .marker_o(mk));
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; held until ack is sampled, the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Counts, then the verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the thousand or so cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_i, ce_i, cyc_i, stb_i, we_i} = 5'h18;
    {adr_i, sel_i, dat_i} = {8'h00, 4'hF, 32'h0};
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped place
    chk({31'h0, irq_o}, 32'h0);
    rd(qe_pkg::OFS_CTRL, 32'h0);
    rd(qe_pkg::OFS_MAXPOS, qe_pkg::MAXPOS_RST);
    rd(qe_pkg::OFS_LOAD, qe_pkg::LOAD_RST);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    $display("test reset done");
    // Phase mode, A only then both channels, then reverse
    wr(qe_pkg::OFS_CTRL, 32'h1);
    enc.move(4, 1'b0);
    rd(qe_pkg::OFS_POS, 32'h2);
    rd(qe_pkg::OFS_STATUS, 32'h0);
    wr(qe_pkg::OFS_CTRL, 32'h9);
    enc.move(4, 1'b0);
    rd(qe_pkg::OFS_POS, 32'h6);
    enc.move(4, 1'b1);
    rd(qe_pkg::OFS_POS, 32'h2);
    rd(qe_pkg::OFS_STATUS, 32'h1);
    rd(qe_pkg::OFS_RIS, 32'h4);
    wr(qe_pkg::OFS_ISC, 32'hF);
    rd(qe_pkg::OFS_RIS, 32'h0);
    // Written position, then swapped channels count the other way
    wr(qe_pkg::OFS_POS, 32'hA);
    wr(qe_pkg::OFS_CTRL, 32'hB);
    enc.move(4, 1'b0);
    rd(qe_pkg::OFS_POS, 32'h6);
    // Clock/direction mode
    wr(qe_pkg::OFS_CTRL, 32'h5);
    repeat (3) enc.cd_step(1'b0);
    rd(qe_pkg::OFS_POS, 32'h9);
    repeat (2) enc.cd_step(1'b1);
    rd(qe_pkg::OFS_POS, 32'h7);
    $display("test counting done");
    // Wrap at both ends of a small range
    wr(qe_pkg::OFS_CTRL, 32'h9);
    wr(qe_pkg::OFS_MAXPOS, 32'h9);
    wr(qe_pkg::OFS_POS, 32'h9);
    enc.move(1, 1'b0);
    rd(qe_pkg::OFS_POS, 32'h0);
    enc.move(1, 1'b1);
    rd(qe_pkg::OFS_POS, 32'h9);
    // Marker: ignored when relative, zero forward, max in reverse
    wr(qe_pkg::OFS_POS, 32'h4);
    enc.mark();
    rd(qe_pkg::OFS_POS, 32'h4);
    wr(qe_pkg::OFS_CTRL, 32'h19);
    enc.move(1, 1'b0);
    enc.mark();
    rd(qe_pkg::OFS_POS, 32'h0);
    wr(qe_pkg::OFS_POS, 32'h4);
    enc.move(1, 1'b1);
    enc.mark();
    rd(qe_pkg::OFS_POS, 32'h9);
    rd(qe_pkg::OFS_RIS, 32'h5);
    $display("test marker done");
    // Phase error, masking and clearing
    wr(qe_pkg::OFS_ISC, 32'hF);
    wr(qe_pkg::OFS_CTRL, 32'h9);
    enc.glitch();
    wb(1'b0, qe_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rdat[1]}, 32'h1);
    wb(1'b0, qe_pkg::OFS_RIS, 32'h0);
    chk({31'h0, rdat[3]}, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    rd(qe_pkg::OFS_ISC, 32'h0);
    wr(qe_pkg::OFS_INTEN, 32'h8);
    chk({31'h0, irq_o}, 32'h1);
    rd(qe_pkg::OFS_ISC, 32'h8);
    wr(qe_pkg::OFS_INTEN, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(qe_pkg::OFS_INTEN, 32'h8);
    wr(qe_pkg::OFS_ISC, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b0, qe_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rdat[1]}, 32'h0);
    $display("test interrupts done");
    // Disabled unit ignores pins; velocity stays idle
    wr(qe_pkg::OFS_ISC, 32'hF);
    wr(qe_pkg::OFS_CTRL, 32'h28);
    wr(qe_pkg::OFS_POS, 32'h7);
    enc.move(4, 1'b0);
    enc.glitch();
    rd(qe_pkg::OFS_POS, 32'h7);
    rd(qe_pkg::OFS_COUNT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    // Velocity: 32-clock period, 8 steps a period, predivide 1, 2, 4
    wr(qe_pkg::OFS_LOAD, 32'h20);
    for (int d = 0; d < 3; d++) begin
      wr(qe_pkg::OFS_CTRL, 32'h29 | (32'(d) << 6));
      fork
        enc.move(40, 1'b0);
        begin
          repeat (100) @(posedge clk_i);
          rd(qe_pkg::OFS_SPEED, 32'h8 >> d);
        end
      join
    end
    // Stopped shaft: running and saved counts fall to zero
    repeat (70) @(posedge clk_i);
    rd(qe_pkg::OFS_COUNT, 32'h0);
    rd(qe_pkg::OFS_SPEED, 32'h0);
    wb(1'b0, qe_pkg::OFS_RIS, 32'h0);
    chk({31'h0, rdat[1]}, 32'h1);
    // Frozen enable hides a full shaft cycle; 7 plus 120 steps on ten places is 7
    ce_i <= 1'b0;
    enc.move(4, 1'b0);
    ce_i <= 1'b1;
    rd(qe_pkg::OFS_POS, 32'h7);
    $display("test velocity done");
    finish_test();
  end
endmodule // test_quadrature_encoder_position_velocity
